// ===== rtl/pmpwp_top.sv
// Behaviour
// - Page 0x00 sends paged commands to channel 0, page 0x01 to channel 1.
// - Page 0xFF applies broadcast-capable writes to all mask-enabled channels at once.
// - Only clear-faults, operation and on/off-config accept broadcast page.
// - Paged read at page 0xFF returns undefined data and raises a CML fault.
// - Non-broadcast paged write at page 0xFF is dropped and raises CML fault.
// - Page selector is unpaged read/write byte at 0x00, reset 0x00.
// - Reads always succeed whatever the protection level.
// - Lock 0x80: only lock, page, unlock, store-all, indirect-pointer writes pass.
// - Lock 0x40 also passes operation, clear-faults, mask, clear-energy, force writes.
// - Lock 0x00 passes all writes; other values are reserved.
// - Lock register is unpaged at 0x10, reset 0x00, nonvolatile-backed.
// - High write-lock pin imposes the intermediate level.
// - Effective protection is the stricter of pin and register.
// - Exponent-mantissa word: 5-bit signed exponent, 11-bit signed mantissa.
// - Unsigned vout word: 16-bit unsigned mantissa, exponent fixed at -13.
// - Global page mask is unpaged byte at 0xE4, default 0x03.
// - Mask bit n enables channel n for broadcast; bits 7:2 read zero.
// - Base bits 6:0 plus pin offset 0..8 form bus address; bit 7 reads zero.
module pmpwp_top #(
  parameter int NUM_CHANNELS = 2,
  parameter logic [15:0] ID_CODE = 16'h0a5a // Arbitrary identification value.
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Decoded command access from the serial front end
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic cmd_paged_i,
  input wire logic [15:0] cmd_wdata_i,
  // Pins
  input wire logic write_lock_pin_i,
  input wire logic addr_select_pin_0_i,
  input wire logic addr_select_pin_1_i,
  input wire logic [3:0] addr_offset_i,
  // Nonvolatile restore
  input wire logic nvm_load_i,
  input wire logic [7:0] nvm_lock_i,
  input wire logic [7:0] nvm_mask_i,
  input wire logic [7:0] nvm_base_i,
  // Read answer
  output logic rsp_valid_o,
  output logic [15:0] rsp_rdata_o,
  // Channel command strobes
  output logic [1:0] chan_wr_o,
  output logic [1:0] chan_rd_o,
  output logic [7:0] chan_cmd_o,
  output logic [15:0] chan_wdata_o,
  // Status
  output logic cml_fault_o,
  output logic write_refused_o,
  output logic [6:0] bus_address_o,
  output logic [7:0] page_o,
  output logic [2:0] lock_state_o,
  // Decoded view of the last written word
  output logic [4:0] exp_o,
  output logic [10:0] mant_o
);

  initial
  begin
    if (NUM_CHANNELS != 2)
      $error("pmpwp_top serves exactly two channels");
  end

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] lock_pin;
    logic [1:0] addr_select_pin_0;
    logic [1:0] addr_select_pin_1;
    logic [3:0] offs0;
    logic [3:0] offs1;
  } pmpwp_sync_s;

  pmpwp_sync_s sync_reg;
  pmpwp_sync_s sync_next;

  always_comb
  begin
    sync_next = sync_reg;
    sync_next.lock_pin = {sync_reg.lock_pin[0], write_lock_pin_i};
    sync_next.addr_select_pin_0 = {sync_reg.addr_select_pin_0[0], addr_select_pin_0_i};
    sync_next.addr_select_pin_1 = {sync_reg.addr_select_pin_1[0], addr_select_pin_1_i};
    sync_next.offs0 = addr_offset_i;
    sync_next.offs1 = sync_reg.offs0;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sync_reg <= '0;
    else
      sync_reg <= sync_next;
  end

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] page;
    logic [7:0] lock;
    logic [1:0] mask;
    logic [6:0] base;
    logic [15:0] ind_cmd;
    logic [15:0] ind_d0;
    logic [15:0] ind_d1;
    logic rsp_valid;
    logic [15:0] rdata;
    logic [1:0] chan_wr;
    logic [1:0] chan_rd;
    logic [7:0] chan_cmd;
    logic [15:0] chan_wdata;
    logic cml;
    logic refused;
    logic [6:0] addr;
    logic [2:0] lock_state;
    logic [4:0] exp;
    logic [10:0] mant;
  } pmpwp_state_s;

  pmpwp_state_s state_reg;
  pmpwp_state_s state_next;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic is_broadcast_cmd(input logic [7:0] c);
    return (c == pmpwp_pkg::CMD_CLEAR_FAULTS) ||
           (c == pmpwp_pkg::CMD_OPERATION) ||
           (c == pmpwp_pkg::CMD_ON_OFF_CONFIG);
  endfunction

  function automatic logic [1:0] page_target(input logic [7:0] p);
    if (p == pmpwp_pkg::PAGE_CH0)
      return 2'b01;
    else if (p == pmpwp_pkg::PAGE_CH1)
      return 2'b10;
    else
      return 2'b00;
  endfunction

  logic allowed;
  pmpwp_pkg::pmpwp_lock_e level;
  logic signed [4:0] dec_exp;
  logic signed [10:0] dec_mant;

  pmpwp_lock_policy u_policy (
    .lock_level_i(state_reg.lock),
    .lock_pin_i(sync_reg.lock_pin[1]),
    .cmd_i(cmd_code_i),
    .allowed_o(allowed),
    .level_o(level)
  );

  pmpwp_format_decode u_decode (
    .word_i(cmd_wdata_i),
    .exp_o(dec_exp),
    .mant_o(dec_mant),
    .vout_mant_o(),
    .vout_exp_o()
  );

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  logic [3:0] offset_clip;
  logic paged_all;

  always_comb
  begin
    state_next = state_reg;
    state_next.rsp_valid = 1'b0;
    state_next.chan_wr = 2'b00;
    state_next.chan_rd = 2'b00;
    state_next.cml = 1'b0;
    state_next.refused = 1'b0;
    state_next.lock_state = level;
    paged_all = cmd_paged_i && (state_reg.page == pmpwp_pkg::PAGE_ALL);
    offset_clip = (sync_reg.offs1 > pmpwp_pkg::ADDR_OFFSET_MAX) ?
                  pmpwp_pkg::ADDR_OFFSET_MAX : sync_reg.offs1;
    // The select pins are synchronised but feed nothing; the offset word sets the sum.
    state_next.addr = state_reg.base + {3'h0, offset_clip};
    if (nvm_load_i)
    begin
      state_next.lock = nvm_lock_i;
      state_next.mask = nvm_mask_i[1:0];
      state_next.base = nvm_base_i[6:0];
    end
    else if (cmd_valid_i && !cmd_write_i)
    begin
      // Reads never consult the lock level.
      state_next.rsp_valid = 1'b1;
      state_next.chan_cmd = cmd_code_i;
      unique case (cmd_code_i)
        pmpwp_pkg::CMD_PAGE_SELECT: state_next.rdata = {8'h00, state_reg.page};
        pmpwp_pkg::CMD_WRITE_LOCK_LEVEL: state_next.rdata = {8'h00, state_reg.lock};
        pmpwp_pkg::CMD_GLOBAL_PAGE_MASK:
          state_next.rdata = {14'h0000, state_reg.mask};
        pmpwp_pkg::CMD_BUS_BASE_ADDRESS:
          state_next.rdata = {9'h000, state_reg.base};
        pmpwp_pkg::CMD_INDIRECT_COMMAND:
          state_next.rdata = {1'b0, state_reg.ind_cmd[14:0]};
        pmpwp_pkg::CMD_INDIRECT_DATA_HOST0: state_next.rdata = state_reg.ind_d0;
        pmpwp_pkg::CMD_INDIRECT_DATA_HOST1: state_next.rdata = state_reg.ind_d1;
        pmpwp_pkg::CMD_ID_CODE: state_next.rdata = ID_CODE;
        default:
        begin
          state_next.rdata = 16'h0000;
          if (paged_all)
            state_next.cml = 1'b1;
          else if (cmd_paged_i)
            state_next.chan_rd = page_target(state_reg.page);
          else
            state_next.chan_rd = 2'b01;
        end
      endcase
    end
    else if (cmd_valid_i && cmd_write_i)
    begin
      if (!allowed)
      begin
        state_next.cml = 1'b1;
        state_next.refused = 1'b1;
      end
      else
      begin
        state_next.exp = dec_exp;
        state_next.mant = dec_mant;
        state_next.chan_cmd = cmd_code_i;
        state_next.chan_wdata = cmd_wdata_i;
        unique case (cmd_code_i)
          pmpwp_pkg::CMD_PAGE_SELECT: state_next.page = cmd_wdata_i[7:0];
          pmpwp_pkg::CMD_WRITE_LOCK_LEVEL: state_next.lock = cmd_wdata_i[7:0];
          pmpwp_pkg::CMD_GLOBAL_PAGE_MASK: state_next.mask = cmd_wdata_i[1:0];
          pmpwp_pkg::CMD_BUS_BASE_ADDRESS: state_next.base = cmd_wdata_i[6:0];
          pmpwp_pkg::CMD_INDIRECT_COMMAND: state_next.ind_cmd = cmd_wdata_i;
          pmpwp_pkg::CMD_INDIRECT_DATA_HOST0: state_next.ind_d0 = cmd_wdata_i;
          pmpwp_pkg::CMD_INDIRECT_DATA_HOST1: state_next.ind_d1 = cmd_wdata_i;
          default:
          begin
            if (paged_all && is_broadcast_cmd(cmd_code_i))
              state_next.chan_wr = state_reg.mask;
            else if (paged_all)
              state_next.cml = 1'b1;
            else if (cmd_paged_i)
              state_next.chan_wr = page_target(state_reg.page);
            else
              state_next.chan_wr = 2'b01;
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= '0;
      state_reg.page <= pmpwp_pkg::PAGE_RESET;
      state_reg.lock <= pmpwp_pkg::LOCK_RESET;
      state_reg.mask <= pmpwp_pkg::MASK_RESET;
      state_reg.base <= pmpwp_pkg::BASE_RESET;
      state_reg.ind_cmd <= pmpwp_pkg::INDIRECT_RESET;
      state_reg.addr <= pmpwp_pkg::BASE_RESET;
      state_reg.lock_state <= 3'b001;
    end
    else
      state_reg <= state_next;
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign rsp_valid_o = state_reg.rsp_valid;
  assign rsp_rdata_o = state_reg.rdata;
  assign chan_wr_o = state_reg.chan_wr;
  assign chan_rd_o = state_reg.chan_rd;
  assign chan_cmd_o = state_reg.chan_cmd;
  assign chan_wdata_o = state_reg.chan_wdata;
  assign cml_fault_o = state_reg.cml;
  assign write_refused_o = state_reg.refused;
  assign bus_address_o = state_reg.addr;
  assign page_o = state_reg.page;
  assign lock_state_o = state_reg.lock_state;
  assign exp_o = state_reg.exp;
  assign mant_o = state_reg.mant;

endmodule

// ===== rtl/pmpwp_pkg.sv
package pmpwp_pkg;

  // ---------------------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CMD_PAGE_SELECT = 8'h00;
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_ON_OFF_CONFIG = 8'h02;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_WRITE_LOCK_LEVEL = 8'h10;
  localparam logic [7:0] CMD_STORE_USER_ALL = 8'h15;
  localparam logic [7:0] CMD_NVM_UNLOCK = 8'hbd;
  localparam logic [7:0] CMD_INDIRECT_COMMAND = 8'hc8;
  localparam logic [7:0] CMD_INDIRECT_DATA_HOST0 = 8'hc9;
  localparam logic [7:0] CMD_INDIRECT_DATA_HOST1 = 8'hca;
  localparam logic [7:0] CMD_CLEAR_ENERGY = 8'hcc;
  localparam logic [7:0] CMD_GOODPIN_OUTPUT_FORCE = 8'hce;
  localparam logic [7:0] CMD_GLOBAL_PAGE_MASK = 8'he4;
  localparam logic [7:0] CMD_BUS_BASE_ADDRESS = 8'he6;
  localparam logic [7:0] CMD_ID_CODE = 8'he7;

  // ---------------------------------------------------------------------------
  // Values and reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] PAGE_CH0 = 8'h00;
  localparam logic [7:0] PAGE_CH1 = 8'h01;
  localparam logic [7:0] PAGE_ALL = 8'hff;
  localparam logic [7:0] LOCK_NONE = 8'h00;
  localparam logic [7:0] LOCK_MID = 8'h40;
  localparam logic [7:0] LOCK_STRICT = 8'h80;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [7:0] LOCK_RESET = 8'h00;
  localparam logic [1:0] MASK_RESET = 2'h3;
  localparam logic [6:0] BASE_RESET = 7'h5c;
  localparam logic [15:0] INDIRECT_RESET = 16'h0000;
  localparam logic [3:0] ADDR_OFFSET_MAX = 4'h8;

  // ---------------------------------------------------------------------------
  // Numeric word formats
  // ---------------------------------------------------------------------------
  localparam int EXP_MSB = 15;
  localparam int EXP_LSB = 11;
  localparam int MANT_MSB = 10;
  localparam logic signed [5:0] VOUT_EXP = -6'sd13;

  typedef enum logic [2:0] {
    PMPWP_LOCK_OPEN = 3'b001,
    PMPWP_LOCK_MID = 3'b010,
    PMPWP_LOCK_STRICT = 3'b100
  } pmpwp_lock_e;

endpackage

// ===== rtl/pmpwp_lock_policy.sv
module pmpwp_lock_policy (
  // Protection state
  input wire logic [7:0] lock_level_i,
  input wire logic lock_pin_i,
  // Command under test
  input wire logic [7:0] cmd_i,
  // Verdict
  output logic allowed_o,
  output pmpwp_pkg::pmpwp_lock_e level_o
);

  // ---------------------------------------------------------------------------
  // Effective level
  // ---------------------------------------------------------------------------
  // Reserved register values are treated as no lock; the pin still applies.
  always_comb
  begin
    if (lock_level_i == pmpwp_pkg::LOCK_STRICT)
      level_o = pmpwp_pkg::PMPWP_LOCK_STRICT;
    else if (lock_pin_i || lock_level_i == pmpwp_pkg::LOCK_MID)
      level_o = pmpwp_pkg::PMPWP_LOCK_MID;
    else
      level_o = pmpwp_pkg::PMPWP_LOCK_OPEN;
  end

  // ---------------------------------------------------------------------------
  // Write filter
  // ---------------------------------------------------------------------------
  logic always_ok;
  logic mid_ok;

  always_comb
  begin
    always_ok = (cmd_i == pmpwp_pkg::CMD_WRITE_LOCK_LEVEL) ||
                (cmd_i == pmpwp_pkg::CMD_PAGE_SELECT) ||
                (cmd_i == pmpwp_pkg::CMD_NVM_UNLOCK) ||
                (cmd_i == pmpwp_pkg::CMD_STORE_USER_ALL) ||
                (cmd_i == pmpwp_pkg::CMD_INDIRECT_COMMAND);
    mid_ok = (cmd_i == pmpwp_pkg::CMD_OPERATION) ||
             (cmd_i == pmpwp_pkg::CMD_CLEAR_FAULTS) ||
             (cmd_i == pmpwp_pkg::CMD_GLOBAL_PAGE_MASK) ||
             (cmd_i == pmpwp_pkg::CMD_CLEAR_ENERGY) ||
             (cmd_i == pmpwp_pkg::CMD_GOODPIN_OUTPUT_FORCE);
    unique case (level_o)
      pmpwp_pkg::PMPWP_LOCK_STRICT: allowed_o = always_ok;
      pmpwp_pkg::PMPWP_LOCK_MID: allowed_o = always_ok || mid_ok;
      default: allowed_o = 1'b1;
    endcase
  end

endmodule

// ===== rtl/pmpwp_format_decode.sv
module pmpwp_format_decode (
  // Raw word
  input wire logic [15:0] word_i,
  // Exponent-mantissa view
  output logic signed [4:0] exp_o,
  output logic signed [10:0] mant_o,
  // Unsigned output-voltage view
  output logic [15:0] vout_mant_o,
  output logic signed [5:0] vout_exp_o
);

  // ---------------------------------------------------------------------------
  // Field split
  // ---------------------------------------------------------------------------
  always_comb
  begin
    exp_o = $signed(word_i[pmpwp_pkg::EXP_MSB:pmpwp_pkg::EXP_LSB]);
    mant_o = $signed(word_i[pmpwp_pkg::MANT_MSB:0]);
    vout_mant_o = word_i;
    vout_exp_o = pmpwp_pkg::VOUT_EXP;
  end

endmodule

// ===== bench/pmpwp_props.sv
module pmpwp_props (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Watched ports
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic cmd_paged_i,
  input wire logic write_lock_pin_i,
  input wire logic [1:0] chan_wr_o,
  input wire logic [1:0] chan_rd_o,
  input wire logic cml_fault_o,
  input wire logic write_refused_o,
  input wire logic [7:0] page_o,
  input wire logic [2:0] lock_state_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic [7:0] c;
  logic bc;
  logic st;
  logic md;
  assign c = cmd_code_i;
  assign bc = c == 8'h01 || c == 8'h02 || c == 8'h03;
  assign st = c == 8'h00 || c == 8'h10 || c == 8'hbd || c == 8'h15 || c == 8'hc8;
  assign md = st || c == 8'h01 || c == 8'h03 || c == 8'he4 || c == 8'hcc || c == 8'hce;
  sequence wr_s;
    cmd_valid_i && cmd_write_i;
  endsequence
  sequence rd_s;
    cmd_valid_i && !cmd_write_i;
  endsequence
  // Its status port still lags a level that has just moved by one cycle, so it must be settled.
  sequence lvl_s(logic [2:0] v);
    lock_state_o == v && $stable(lock_state_o);
  endsequence
  page0_route_a:
    assert property (wr_s ##0 cmd_paged_i && bc && page_o == 8'h00 ##0 lvl_s(3'b001)
      |=> chan_wr_o == 2'b01) else $error("page 0 write missed channel 0");
  page1_route_a:
    assert property (wr_s ##0 cmd_paged_i && bc && page_o == 8'h01 ##0 lvl_s(3'b001)
      |=> chan_wr_o == 2'b10) else $error("page 1 write missed channel 1");
  bcast_read_a:
    assert property (rd_s ##0 cmd_paged_i && page_o == 8'hff
      |=> cml_fault_o && chan_rd_o == 2'b00) else $error("broadcast read not faulted");
  bcast_drop_a:
    assert property (wr_s ##0 cmd_paged_i && page_o == 8'hff && !bc
      |=> cml_fault_o && chan_wr_o == 2'b00) else $error("broadcast write not dropped");
  strict_lock_a:
    assert property (wr_s ##0 !st ##0 lvl_s(3'b100)
      |=> write_refused_o && cml_fault_o && chan_wr_o == 2'b00)
      else $error("strict level let a write through");
  mid_lock_a:
    assert property (wr_s ##0 !md ##0 lvl_s(3'b010) |=> write_refused_o && cml_fault_o)
      else $error("mid level let a write through");
  read_free_a:
    assert property (rd_s ##0 !(cmd_paged_i && page_o == 8'hff)
      |=> !cml_fault_o && !write_refused_o) else $error("read was refused");
  open_pass_a:
    assert property (wr_s ##0 !(cmd_paged_i && page_o > 8'h01) ##0 lvl_s(3'b001)
      |=> !write_refused_o && !cml_fault_o) else $error("open level refused a write");
  pin_level_a:
    assert property (write_lock_pin_i [*4] |-> lock_state_o != 3'b001)
      else $error("lock pin ignored");
endmodule

// ===== bench/pmpwp_host.sv
module pmpwp_host (
  // Clock
  input wire logic core_clk_i,
  // Command access
  output logic cmd_valid_o,
  output logic cmd_write_o,
  output logic [7:0] cmd_code_o,
  output logic cmd_paged_o,
  output logic [15:0] cmd_wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    cmd_valid_o = 1'b0;
    cmd_write_o = 1'b0;
    cmd_code_o = 8'h00;
    cmd_paged_o = 1'b0;
    cmd_wdata_o = 16'h0000;
  end
  // Idle fields are inverted so a design that samples them without valid is caught.
  task automatic access(input logic w, input logic [7:0] code, input logic p,
                        input logic [15:0] d);
    @(posedge core_clk_i);
    cmd_valid_o <= 1'b1;
    cmd_write_o <= w;
    cmd_code_o <= code;
    cmd_paged_o <= p;
    cmd_wdata_o <= d;
    @(posedge core_clk_i);
    cmd_valid_o <= 1'b0;
    cmd_write_o <= ~w;
    cmd_code_o <= ~code;
    cmd_paged_o <= ~p;
    cmd_wdata_o <= ~d;
  endtask
endmodule

// ===== bench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cmd_valid_i, cmd_write_i, cmd_paged_i;
  logic [7:0] cmd_code_i;
  logic [15:0] cmd_wdata_i;
  logic write_lock_pin_i = 1'b0;
  logic addr_select_pin_0_i = 1'b1;
  logic addr_select_pin_1_i = 1'b1;
  logic [3:0] addr_offset_i = 4'h8;
  logic nvm_load_i = 1'b0;
  logic [7:0] nvm_lock_i = 8'h00;
  logic [7:0] nvm_mask_i = 8'h00;
  logic [7:0] nvm_base_i = 8'h00;
  logic rsp_valid_o, cml_fault_o, write_refused_o;
  logic [15:0] rsp_rdata_o, chan_wdata_o;
  logic [1:0] chan_wr_o, chan_rd_o;
  logic [7:0] chan_cmd_o, page_o;
  logic [6:0] bus_address_o;
  logic [2:0] lock_state_o;
  logic [4:0] exp_o;
  logic [10:0] mant_o;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #50 core_clk_i = ~core_clk_i;
  pmpwp_host pmpwp_host_inst (.core_clk_i, .cmd_valid_o(cmd_valid_i),
    .cmd_write_o(cmd_write_i), .cmd_code_o(cmd_code_i), .cmd_paged_o(cmd_paged_i),
    .cmd_wdata_o(cmd_wdata_i));
  pmpwp_top pmpwp_top_inst (.core_clk_i, .rst_n_i, .cmd_valid_i, .cmd_write_i,
    .cmd_code_i, .cmd_paged_i, .cmd_wdata_i, .write_lock_pin_i, .addr_select_pin_0_i,
    .addr_select_pin_1_i, .addr_offset_i, .nvm_load_i, .nvm_lock_i, .nvm_mask_i,
    .nvm_base_i, .rsp_valid_o, .rsp_rdata_o, .chan_wr_o, .chan_rd_o, .chan_cmd_o,
    .chan_wdata_o, .cml_fault_o, .write_refused_o, .bus_address_o, .page_o,
    .lock_state_o, .exp_o, .mant_o);
  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] code, input logic p,
                     input logic [15:0] d);
    pmpwp_host_inst.access(w, code, p, d);
    @(negedge core_clk_i);
  endtask
  // Status nibble is refused, fault, then the two channel strobes.
  task automatic wr(input logic [7:0] code, input logic p, input logic [15:0] d,
                    input logic [3:0] e);
    acc(1'b1, code, p, d);
    chk({12'h000, write_refused_o, cml_fault_o, chan_wr_o}, {12'h000, e});
  endtask
  task automatic rd(input logic [7:0] code, input logic [15:0] e);
    acc(1'b0, code, 1'b0, 16'h0000);
    chk(rsp_rdata_o, e);
  endtask
  task automatic settle(input int n, input logic [2:0] e);
    repeat (n) @(negedge core_clk_i);
    chk({13'h0000, lock_state_o}, {13'h0000, e});
  endtask
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      close_out();
    end
  end
  initial
  begin
    repeat (10) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rd(8'h00, 16'h0000);
    rd(8'h10, 16'h0000);
    rd(8'he4, 16'h0003);
    rd(8'he6, 16'h005c);
    chk({9'h000, bus_address_o}, 16'h0064);
    wr(8'h00, 1'b0, 16'h0001, 4'h0);
    wr(8'h01, 1'b1, 16'h0080, 4'h2);
    wr(8'h00, 1'b0, 16'h0000, 4'h0);
    wr(8'h02, 1'b1, 16'h0080, 4'h1);
    wr(8'h00, 1'b0, 16'h00ff, 4'h0);
    rd(8'h00, 16'h00ff);
    for (int i = 1; i < 4; i++)
      wr(8'(i), 1'b1, 16'h0000, 4'h3);
    wr(8'hd0, 1'b1, 16'h0000, 4'h4);
    acc(1'b0, 8'h8b, 1'b1, 16'h0000);
    chk({14'h0000, cml_fault_o, |chan_rd_o}, 16'h0002);
    wr(8'he4, 1'b0, 16'h00fe, 4'h0);
    rd(8'he4, 16'h0002);
    wr(8'h03, 1'b1, 16'h0000, 4'h2);
    wr(8'h00, 1'b0, 16'h0005, 4'h0);
    acc(1'b1, 8'h01, 1'b1, 16'h0000);
    chk({14'h0000, chan_wr_o}, 16'h0000);
    wr(8'h00, 1'b0, 16'h0000, 4'h0);
    wr(8'h10, 1'b0, 16'h0080, 4'h0);
    settle(1, 3'b100);
    wr(8'he4, 1'b0, 16'h0001, 4'hc);
    rd(8'he4, 16'h0002);
    wr(8'h00, 1'b0, 16'h0000, 4'h0);
    wr(8'h10, 1'b0, 16'h0040, 4'h0);
    settle(1, 3'b010);
    wr(8'he4, 1'b0, 16'h0003, 4'h0);
    wr(8'he6, 1'b0, 16'h0010, 4'hc);
    wr(8'h01, 1'b1, 16'h0000, 4'h1);
    wr(8'h10, 1'b0, 16'h0000, 4'h0);
    settle(1, 3'b001);
    wr(8'he6, 1'b0, 16'h0090, 4'h0);
    rd(8'he6, 16'h0010);
    chk({9'h000, bus_address_o}, 16'h0018);
    @(posedge core_clk_i);
    write_lock_pin_i <= 1'b1;
    settle(4, 3'b010);
    wr(8'he6, 1'b0, 16'h0020, 4'hc);
    wr(8'h10, 1'b0, 16'h0080, 4'h0);
    settle(1, 3'b100);
    wr(8'h10, 1'b0, 16'h0000, 4'h0);
    settle(1, 3'b010);
    @(posedge core_clk_i);
    write_lock_pin_i <= 1'b0;
    addr_offset_i <= 4'h3;
    addr_select_pin_1_i <= 1'b0;
    settle(4, 3'b001);
    chk({9'h000, bus_address_o}, 16'h0013);
    wr(8'hc8, 1'b0, 16'hd280, 4'h0);
    chk({11'h000, exp_o}, 16'h001a);
    chk({5'h00, mant_o}, 16'h0280);
    @(posedge core_clk_i);
    nvm_load_i <= 1'b1;
    nvm_lock_i <= 8'h40;
    nvm_mask_i <= 8'h01;
    nvm_base_i <= 8'h30;
    @(posedge core_clk_i);
    nvm_load_i <= 1'b0;
    rd(8'h10, 16'h0040);
    rd(8'he4, 16'h0001);
    rd(8'he6, 16'h0030);
    close_out();
  end
endmodule
bind pmpwp_top pmpwp_props pmpwp_props_inst (.core_clk_i, .rst_n_i, .cmd_valid_i,
  .cmd_write_i, .cmd_code_i, .cmd_paged_i, .write_lock_pin_i, .chan_wr_o, .chan_rd_o,
  .cml_fault_o, .write_refused_o, .page_o, .lock_state_o);
